// File: include/ais_pkg.sv
package ais_pkg;

    // register byte addresses on the 8-bit register port
    localparam logic [7:0] RESULT_LOW_OFFSET   = 8'h78;
    localparam logic [7:0] RESULT_HIGH_OFFSET  = 8'h79;
    localparam logic [7:0] STATUS_OFFSET       = 8'h7A;
    localparam logic [7:0] SELECT_OFFSET       = 8'h7C;
    localparam logic [7:0] MASK_OFFSET         = 8'h7D;

    // adc_input_reference_select field positions
    localparam int REF_SEL_MSB     = 7;
    localparam int REF_SEL_LSB     = 6;
    localparam int LEFT_ALIGN_BIT  = 5;
    localparam int CHAN_SEL_MSB    = 3;
    localparam int CHAN_SEL_LSB    = 0;
    localparam logic [7:0] SELECT_RESET = 8'h00;

    // status and mask share one layout
    localparam int DONE_FLAG_BIT    = 4;
    localparam int OVERRUN_FLAG_BIT = 0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // reference codes
    localparam logic [1:0] REF_EXTERNAL_PIN  = 2'h0;
    localparam logic [1:0] REF_ANALOG_SUPPLY = 2'h1;
    localparam logic [1:0] REF_RESERVED      = 2'h2;
    localparam logic [1:0] REF_INTERNAL_1V1  = 2'h3;

    // channel codes
    localparam logic [3:0] CHAN_LAST_PIN     = 4'h4;
    localparam logic [3:0] CHAN_TEMP_SENSOR  = 4'h8;

    // converter geometry
    localparam int RESULT_BITS = 10;
    localparam logic [9:0] CODE_ZERO = 10'h000;
    localparam logic [9:0] CODE_MSB  = 10'h200;
    localparam logic [3:0] TOP_BIT_INDEX = 4'h9;

    // comparator settling time per bit trial, least time rounds up
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS     = 400;
    localparam int SETTLE_CYCLES =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SETTLE_RELOAD = 3'(SETTLE_CYCLES - 1);

    typedef enum logic [1:0] {
        SAR_IDLE   = 2'b00,
        SAR_SETTLE = 2'b01
    } ais_sar_state_t;

endpackage

// File: src/ais_sar_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ais_sar_engine (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic       comparatorHigh,
    output logic [9:0]      dacCode,
    output logic            busy,
    output logic            done,
    output logic [9:0]      result
);
    import ais_pkg::*;

    typedef struct packed {
        ais_sar_state_t state;
        logic [9:0]     code;
        logic [3:0]     bitIdx;
        logic [2:0]     waitCnt;
        logic           done;
        logic [9:0]     result;
        logic           cmpMeta;
        logic           cmpSync;
    } ais_sar_t;

    ais_sar_t s_reg;
    ais_sar_t s_next;

    // binary search, msb first; each trial waits for the comparator to
    // settle and pass the two-stage synchroniser before it is judged
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.cmpMeta = comparatorHigh;
        s_next.cmpSync = s_reg.cmpMeta;
        case (s_reg.state)
            SAR_IDLE: begin
                if (start) begin
                    s_next.state = SAR_SETTLE;
                    s_next.code = CODE_MSB;
                    s_next.bitIdx = TOP_BIT_INDEX;
                    s_next.waitCnt = SETTLE_RELOAD;
                end
            end
            SAR_SETTLE: begin
                if (s_reg.waitCnt != 3'h0) begin
                    s_next.waitCnt = s_reg.waitCnt - 3'h1;
                end else begin
                    // keep the trial bit only while input >= dac level
                    if (!s_reg.cmpSync) begin
                        s_next.code[s_reg.bitIdx] = 1'b0;
                    end
                    if (s_reg.bitIdx == 4'h0) begin
                        // 10 bits cap the code at 0x3FF, ground gives 0
                        s_next.result = s_next.code;
                        s_next.done = 1'b1;
                        s_next.state = SAR_IDLE;
                    end else begin
                        s_next.bitIdx = s_reg.bitIdx - 4'h1;
                        s_next.code[s_reg.bitIdx - 4'h1] = 1'b1;
                        s_next.waitCnt = SETTLE_RELOAD;
                    end
                end
            end
            default: begin
                s_next.state = SAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dacCode = s_reg.code;
    assign busy    = (s_reg.state != SAR_IDLE);
    assign done    = s_reg.done;
    assign result  = s_reg.result;
endmodule
`default_nettype wire

// File: src/ais_input_select.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - single-ended code equals input times 1024 over the selected reference
// - code zero means ground; 0x3FF means reference less one step
// - after completion flag sets, result registers hold that conversion
// - channel code 1000 routes and enables the temperature sensor
// - reference bits 7:6: 00 external pin, internal off; 01 supply
// - reference code 11 is internal 1.1 V; code 10 is reserved
// - reference change during a conversion applies after it completes
// - channel change during a conversion applies after it completes
// - bit 5 set left-aligns the result, clear right-aligns it
// - alignment change shows at once, even mid-conversion
// - channel codes 0000 to 0100 route the matching analog input pin
// - left alignment uses bits 15:6, right alignment bits 9:0
// - after a low byte read, data holds until the high byte read
// - completion flag sets when the result lands in the data registers
module ais_input_select (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regReadData,
    input  wire logic       convStart,
    input  wire logic       comparatorHigh,
    output logic [9:0]      dacCode,
    output logic            conversionBusy,
    output logic [3:0]      channelSelect,
    output logic            tempSensorEnable,
    output logic [1:0]      referenceSelect,
    output logic            externalRefOnly,
    output logic            analogSupplyRefEnable,
    output logic            internalRefEnable,
    output logic            irq
);
    import ais_pkg::*;

    typedef struct packed {
        logic [1:0] refSel;
        logic       leftAlign;
        logic [3:0] chanSel;
        logic [1:0] appliedRef;
        logic [3:0] appliedChan;
        logic [9:0] result;
        logic       readLock;
        logic       doneFlag;
        logic       overrunFlag;
        logic [1:0] irqMask;
        logic [7:0] readData;
        logic       tempEn;
        logic       extOnly;
        logic       supplyEn;
        logic       intEn;
    } ais_select_t;

    ais_select_t s_reg;
    ais_select_t s_next;

    logic       sarBusy;
    logic       sarDone;
    logic [9:0] sarResult;

    // present the 10-bit result inside the 16-bit pair
    function automatic logic [15:0] formatResult(input logic [9:0] value,
                                                 input logic left);
        if (left) begin
            formatResult = {value, 6'h00};
        end else begin
            formatResult = {6'h00, value};
        end
    endfunction

    // status and mask share one layout
    function automatic logic [7:0] flagByte(input logic done,
                                            input logic overrun);
        logic [7:0] b;
        b = 8'h00;
        b[DONE_FLAG_BIT] = done;
        b[OVERRUN_FLAG_BIT] = overrun;
        flagByte = b;
    endfunction

    // successive approximation core, started only while idle
    ais_sar_engine u_sar (
        .core_clk       (core_clk),
        .reset          (reset),
        .start          (convStart),
        .comparatorHigh (comparatorHigh),
        .dacCode        (dacCode),
        .busy           (sarBusy),
        .done           (sarDone),
        .result         (sarResult)
    );

    // register port, deferred selection and result capture
    always_comb begin
        logic [15:0] shown;
        shown = formatResult(s_reg.result, s_reg.leftAlign);
        s_next = s_reg;
        s_next.readData = 8'h00;

        // software writes; bit 4 of the select register is dropped
        if (regWrite) begin
            case (regAddr)
                SELECT_OFFSET: begin
                    s_next.refSel =
                        regWriteData[REF_SEL_MSB:REF_SEL_LSB];
                    s_next.leftAlign =
                        regWriteData[LEFT_ALIGN_BIT];
                    s_next.chanSel =
                        regWriteData[CHAN_SEL_MSB:CHAN_SEL_LSB];
                end
                STATUS_OFFSET: begin
                    // write one to clear
                    if (regWriteData[DONE_FLAG_BIT]) begin
                        s_next.doneFlag = 1'b0;
                    end
                    if (regWriteData[OVERRUN_FLAG_BIT]) begin
                        s_next.overrunFlag = 1'b0;
                    end
                end
                MASK_OFFSET: begin
                    s_next.irqMask = {regWriteData[DONE_FLAG_BIT],
                                      regWriteData[OVERRUN_FLAG_BIT]};
                end
                default: begin
                end
            endcase
        end

        // reads answer one cycle later; unmapped addresses read zero
        if (regRead) begin
            case (regAddr)
                RESULT_LOW_OFFSET: begin
                    s_next.readData = shown[7:0];
                    s_next.readLock = 1'b1;
                end
                RESULT_HIGH_OFFSET: begin
                    s_next.readData = shown[15:8];
                    s_next.readLock = 1'b0;
                end
                SELECT_OFFSET: begin
                    // bit 4 always reads zero
                    s_next.readData = {s_reg.refSel, s_reg.leftAlign,
                                       1'b0, s_reg.chanSel};
                end
                STATUS_OFFSET: begin
                    s_next.readData = flagByte(s_reg.doneFlag,
                                               s_reg.overrunFlag);
                end
                MASK_OFFSET: begin
                    s_next.readData = flagByte(s_reg.irqMask[1],
                                               s_reg.irqMask[0]);
                end
                default: begin
                end
            endcase
        end

        // completion; a set beats a same-cycle clear. while the pair is
        // locked the new result is discarded and flagged as an overrun
        if (sarDone) begin
            if (s_next.readLock) begin
                s_next.overrunFlag = 1'b1;
            end else begin
                s_next.result = sarResult;
                s_next.doneFlag = 1'b1;
            end
        end

        // selection reaches the analog side only while no conversion runs;
        // sar busy falls with the done pulse, so a held write lands at the
        // same edge as the completion flag
        if (!sarBusy) begin
            s_next.appliedRef = s_reg.refSel;
            s_next.appliedChan = s_reg.chanSel;
        end

        // switch controls decoded from the applied selection
        s_next.tempEn =
            (s_next.appliedChan == CHAN_TEMP_SENSOR);
        // reserved code 10 behaves as the external pin, internal off
        s_next.extOnly =
            (s_next.appliedRef == REF_EXTERNAL_PIN) ||
            (s_next.appliedRef == REF_RESERVED);
        s_next.supplyEn =
            (s_next.appliedRef == REF_ANALOG_SUPPLY);
        s_next.intEn =
            (s_next.appliedRef == REF_INTERNAL_1V1);
    end

    // everything, selection fields included, resets to zero except extOnly, which resets to one
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.extOnly <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // channel codes 0..4 pick the matching pin; the mux decodes the rest
    assign channelSelect         = s_reg.appliedChan;
    assign tempSensorEnable      = s_reg.tempEn;
    assign referenceSelect       = s_reg.appliedRef;
    assign externalRefOnly       = s_reg.extOnly;
    assign analogSupplyRefEnable = s_reg.supplyEn;
    assign internalRefEnable     = s_reg.intEn;
    assign conversionBusy        = sarBusy;
    assign regReadData           = s_reg.readData;

    // level interrupt from unmasked sticky flags
    assign irq = (s_reg.doneFlag & s_reg.irqMask[1]) |
                 (s_reg.overrunFlag & s_reg.irqMask[0]);
endmodule
`default_nettype wire

// File: tb/ais_input_select_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ais_input_select_checker
    import ais_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regReadData,
    input wire logic       convStart,
    input wire logic       comparatorHigh,
    input wire logic [9:0] dacCode,
    input wire logic       conversionBusy,
    input wire logic [3:0] channelSelect,
    input wire logic       tempSensorEnable,
    input wire logic [1:0] referenceSelect,
    input wire logic       externalRefOnly,
    input wire logic       analogSupplyRefEnable,
    input wire logic       internalRefEnable,
    input wire logic       irq
);
    // one clock domain, so clock and disable are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    a_start_busy: assert property (
        convStart && !conversionBusy |=> conversionBusy)
        else $error("start did not raise busy");
    a_busy_holds: assert property (
        $rose(conversionBusy) |-> ##37 conversionBusy)
        else $error("conversion ended early");
    a_busy_ends: assert property (
        $rose(conversionBusy) |-> ##[39:40] !conversionBusy)
        else $error("conversion ran too long");
    a_chan_held: assert property (
        conversionBusy && $past(conversionBusy) |-> $stable(channelSelect))
        else $error("channel moved mid conversion");
    a_ref_held: assert property (
        conversionBusy && $past(conversionBusy) |-> $stable(referenceSelect))
        else $error("reference moved mid conversion");
    a_ref_decode: assert property (
        {externalRefOnly, analogSupplyRefEnable, internalRefEnable} ==
        {referenceSelect[0] == 1'b0, referenceSelect == 2'h1,
         referenceSelect == 2'h3})
        else $error("reference decode wrong");
    a_temp_decode: assert property (
        tempSensorEnable == (channelSelect == CHAN_TEMP_SENSOR))
        else $error("sensor enable wrong");
    a_unused_bit: assert property (
        $past(regRead) && $past(regAddr) == SELECT_OFFSET
        |-> !regReadData[4])
        else $error("select bit 4 read as one");
    a_unmapped_read: assert property (
        $past(regRead) && !($past(regAddr) inside {8'h78, 8'h79, 8'h7A,
        8'h7C, 8'h7D}) |-> regReadData == 8'h00)
        else $error("unmapped read not zero");
    // idle write reaches the applied selection two edges later
    a_sel_apply: assert property (
        $past(regWrite, 2) && $past(regAddr, 2) == SELECT_OFFSET &&
        !$past(conversionBusy, 2) && !$past(conversionBusy)
        |-> {referenceSelect, channelSelect} ==
        {$past(regWriteData[7:6], 2), $past(regWriteData[3:0], 2)})
        else $error("selection not applied");
endmodule
bind ais_input_select ais_input_select_checker u_chk (.*);
`default_nettype wire

// File: tb/ais_input_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ais_input_select_tb;
    import ais_pkg::*;
    logic       core_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWriteData = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regReadData;
    logic       convStart = 1'b0;
    logic       comparatorHigh = 1'b0;
    logic [9:0] dacCode;
    logic       conversionBusy;
    logic [3:0] channelSelect;
    logic       tempSensorEnable;
    logic [1:0] referenceSelect;
    logic       externalRefOnly;
    logic       analogSupplyRefEnable;
    logic       internalRefEnable;
    logic       irq;
    logic [9:0] tgt = 10'h000;
    int         error_cnt = 0;
    int         check_count = 0;

    always #50 core_clk = ~core_clk;
    // ideal comparator: the search settles on tgt exactly
    always @(posedge core_clk) comparatorHigh <= (tgt >= dacCode);

    ais_input_select u_dut (.*);

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                       input string nm);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk(nm, {8'h00, e}, {8'h00, regReadData});
    endtask

    task automatic rpair(input logic [9:0] c, input logic l);
        logic [15:0] f;
        f = l ? {c, 6'h00} : {6'h00, c};
        rdc(RESULT_LOW_OFFSET, f[7:0], "low");
        rdc(RESULT_HIGH_OFFSET, f[15:8], "high");
    endtask

    task automatic go(input logic [9:0] t);
        tgt <= t;
        @(posedge core_clk);
        convStart <= 1'b1;
        @(posedge core_clk);
        convStart <= 1'b0;
    endtask

    // step past the start edge so busy is seen after it has risen
    task automatic fin;
        #1;
        for (int i = 0; i < 60 && conversionBusy !== 1'b0; i++) begin
            @(posedge core_clk);
            #1;
        end
        chk("busy", 16'h0000, {15'h0, conversionBusy});
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(30000 * 100);
        error_cnt++;
        final_report;
    end

    initial begin
        logic [9:0] c;
        logic [7:0] s;
        logic [3:0] ch;
        void'($urandom(32'hF3DA3B46));
        repeat (16) @(posedge core_clk);
        reset <= 1'b0;
        rdc(SELECT_OFFSET, 8'h00, "select");
        rdc(STATUS_OFFSET, 8'h00, "status");
        rdc(8'h7B, 8'h00, "unmapped");
        wr(SELECT_OFFSET, 8'hFF);
        rdc(SELECT_OFFSET, 8'hEF, "select");
        // every reference code, then each pin channel and the sensor
        for (int i = 0; i < 4; i++) begin
            wr(SELECT_OFFSET, {i[1:0], 6'h00});
            @(posedge core_clk);
            #1;
            chk("refdec", {11'h0, i[1:0], i[0] == 0, i == 1, i == 3},
                {11'h0, referenceSelect, externalRefOnly,
                 analogSupplyRefEnable, internalRefEnable});
        end
        for (int i = 0; i < 6; i++) begin
            ch = (i == 5) ? CHAN_TEMP_SENSOR : 4'(i);
            wr(SELECT_OFFSET, {(i == 5) ? REF_INTERNAL_1V1 : REF_EXTERNAL_PIN,
               2'h0, ch});
            @(posedge core_clk);
            #1;
            chk("chan", {11'h0, ch, ch == 4'h8},
                {11'h0, channelSelect, tempSensorEnable});
        end
        // random codes with both ends of the range first
        for (int i = 0; i < 10; i++) begin
            c = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
            s = 8'($urandom) & 8'hEF;
            // the sensor channel is only converted against the 1.1 V ref
            if (s[3:0] == CHAN_TEMP_SENSOR) begin
                s[7:6] = REF_INTERNAL_1V1;
            end
            wr(SELECT_OFFSET, s);
            wr(STATUS_OFFSET, 8'hFF);
            go(c);
            fin;
            rdc(STATUS_OFFSET, 8'h10, "done");
            rpair(c, s[5]);
        end
        // selection deferred, alignment live, mid conversion
        wr(SELECT_OFFSET, 8'h41);
        go(10'h155);
        wr(SELECT_OFFSET, 8'hE8);
        chk("held", 16'h0011, {10'h0, referenceSelect, channelSelect});
        rpair(c, 1'b1);
        fin;
        // the held selection lands one edge after busy falls
        @(posedge core_clk);
        #1;
        chk("applied", 16'h0038, {10'h0, referenceSelect, channelSelect});
        rpair(10'h155, 1'b1);
        // low read locks the pair against the next result
        wr(STATUS_OFFSET, 8'hFF);
        rdc(RESULT_LOW_OFFSET, 8'h40, "low");
        go(10'h2AA);
        fin;
        rdc(STATUS_OFFSET, 8'h01, "overrun");
        rdc(RESULT_HIGH_OFFSET, 8'h55, "high");
        go(10'h2AA);
        fin;
        rpair(10'h2AA, 1'b1);
        // interrupt raised, cleared, then masked
        wr(STATUS_OFFSET, 8'hFF);
        wr(MASK_OFFSET, 8'h10);
        rdc(MASK_OFFSET, 8'h10, "mask");
        go(10'h0F0);
        fin;
        @(posedge core_clk);
        #1;
        chk("irq", 16'h0001, {15'h0, irq});
        wr(STATUS_OFFSET, 8'h10);
        @(posedge core_clk);
        #1;
        chk("irqclr", 16'h0000, {15'h0, irq});
        wr(MASK_OFFSET, 8'h00);
        go(10'h0F0);
        fin;
        @(posedge core_clk);
        #1;
        chk("irqmask", 16'h0000, {15'h0, irq});
        final_report;
    end
endmodule
`default_nettype wire
